/* hw/brap_pkg.sv */
// Constants shared by the burst read address pointer and its status alias.
`default_nettype none
package brap_pkg;
    // -------------------------------------------------------------------------
    // Address map
    // -------------------------------------------------------------------------
    localparam logic [7:0] BRAP_ADDR_STATUS = 8'h00;
    localparam logic [7:0] BRAP_ADDR_X_MSB = 8'h01;
    localparam logic [7:0] BRAP_ADDR_Y_MSB = 8'h03;
    localparam logic [7:0] BRAP_ADDR_Z_MSB = 8'h05;
    localparam logic [7:0] BRAP_ADDR_LAST = 8'h79;
    localparam logic [7:0] BRAP_ADDR_RANGE_LO = 8'h68;
    localparam logic [7:0] BRAP_ADDR_RANGE_HI = 8'h78;
    localparam logic [7:0] BRAP_ADDR_STEP = 8'h01;
    localparam logic [7:0] BRAP_PTR_RESET = 8'h00;
    // -------------------------------------------------------------------------
    // Status alias fields and reset value
    // -------------------------------------------------------------------------
    localparam logic [7:0] BRAP_STATUS_RESET = 8'h00;
    localparam logic [1:0] BRAP_FMODE_SAMPLE = 2'h0;
    localparam int BRAP_DR_BIT = 0;
    localparam int BRAP_OW_BIT = 4;
    localparam int BRAP_ZYXDR_BIT = 3;
    localparam int BRAP_ZYXOW_BIT = 7;
    localparam int BRAP_AXES = 3;
    // -------------------------------------------------------------------------
    // Crossing depth
    // -------------------------------------------------------------------------
    localparam int BRAP_SYNC_STAGES = 2;
endpackage : brap_pkg
`default_nettype wire

/* hw/brap_sync.sv */
// Two flip-flop level synchroniser, one per bit of a bus.
`default_nettype none
module brap_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] din,
    input wire logic [WIDTH-1:0] rst_val,
    input wire logic rst_en,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] dout_r;
    logic [WIDTH-1:0] dout_nxt;

    always_comb begin
        meta_nxt = rst_en ? rst_val : din;
        dout_nxt = rst_en ? rst_val : meta_r;
    end

    always_ff @(posedge clk) begin
        meta_r <= meta_nxt;
        dout_r <= dout_nxt;
    end

    assign dout = dout_r;
endmodule : brap_sync
`default_nettype wire

/* hw/brap_top.sv */
// Burst read address pointer on the serial clock and status alias on MCLK.
// Summary of operation
// R1 - Pointer advances per byte only in bursts.
// R2 - I2C stop rewinds pointer to zero.
// R3 - SPI stop keeps pointer until new address.
// R4 - Range 0x68 to 0x78 steps consecutively.
// R5 - Address 0x79 reserved, pointer holds there.
// R6 - Status shows sample flags or FIFO flags.
// R7 - Status is eight read-only bits, reset zero.
// R8 - Burst from zero gives status then data.
// R9 - All-axis overwrite set, cleared after MSB reads.
// R10 - Host writes never touch the status flags.
`default_nettype none
module brap_top
    import brap_pkg::*;
#(
    parameter int AXES = BRAP_AXES
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic LINK_CLK,
    input wire logic ADDR_LOAD,
    input wire logic [7:0] ADDR_IN,
    input wire logic BURST_RD,
    input wire logic BYTE_DONE,
    input wire logic STOP_DET,
    input wire logic SPI_SEL,
    input wire logic [1:0] F_MODE,
    input wire logic [7:0] FIFO_FLAGS,
    input wire logic NEW_X,
    input wire logic NEW_Y,
    input wire logic NEW_Z,
    output logic [7:0] PTR,
    output logic [7:0] STATUS_Q
);
    // -------------------------------------------------------------------------
    // Link domain reset
    // -------------------------------------------------------------------------
    logic lrst_n;

    brap_sync #(
        .WIDTH(1)
    ) u_lrst (
        .clk(LINK_CLK),
        .din(RST_B),
        .rst_val(1'b0),
        .rst_en(1'b0),
        .dout(lrst_n)
    );

    // -------------------------------------------------------------------------
    // Address pointer, link domain
    // -------------------------------------------------------------------------
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic [AXES-1:0] rd_tgl_r;
    logic [AXES-1:0] rd_tgl_nxt;
    logic burst_byte;

    assign burst_byte = BYTE_DONE && BURST_RD;

    always_comb begin
        ptr_nxt = ptr_r;
        rd_tgl_nxt = rd_tgl_r;
        if (!lrst_n) begin
            ptr_nxt = BRAP_PTR_RESET;
            rd_tgl_nxt = '0;
        end else begin
            // A byte taken from an axis high register tells MCLK to clear flags.
            if (BYTE_DONE) begin
                rd_tgl_nxt[0] = rd_tgl_r[0] ^ (ptr_r == BRAP_ADDR_X_MSB);
                rd_tgl_nxt[1] = rd_tgl_r[1] ^ (ptr_r == BRAP_ADDR_Y_MSB);
                rd_tgl_nxt[2] = rd_tgl_r[2] ^ (ptr_r == BRAP_ADDR_Z_MSB);
            end
            if (ADDR_LOAD) begin
                ptr_nxt = ADDR_IN; // see R3
            end else if (STOP_DET && !SPI_SEL) begin
                ptr_nxt = BRAP_PTR_RESET; // see R2
            end else if (burst_byte && ptr_r != BRAP_ADDR_LAST) begin
                ptr_nxt = ptr_r + BRAP_ADDR_STEP; // see R1 see R4 see R8
            end
            // The reserved top address has no successor and simply holds.
        end
    end

    always_ff @(posedge LINK_CLK) begin
        ptr_r <= ptr_nxt;
        rd_tgl_r <= rd_tgl_nxt;
    end

    assign PTR = ptr_r;

    // -------------------------------------------------------------------------
    // Pointer checks
    // -------------------------------------------------------------------------
    AST_STOP_REWIND: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // see R2
        STOP_DET && !SPI_SEL && !ADDR_LOAD |=> ptr_r == BRAP_PTR_RESET)
        else $error("pointer not rewound on stop");
    AST_SPI_KEEP: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // see R3
        SPI_SEL && !ADDR_LOAD && !burst_byte |=> $stable(ptr_r))
        else $error("pointer moved in spi mode without burst");
    AST_NO_INC_SINGLE: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // see R1
        BYTE_DONE && !BURST_RD && !ADDR_LOAD && !STOP_DET |=> $stable(ptr_r))
        else $error("pointer advanced outside a burst");
    AST_INC_RANGE: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // see R4
        burst_byte && !ADDR_LOAD && !STOP_DET && ptr_r >= BRAP_ADDR_RANGE_LO
        && ptr_r <= BRAP_ADDR_RANGE_HI
        |=> ptr_r == $past(ptr_r) + BRAP_ADDR_STEP)
        else $error("pointer did not step in upper range");
    AST_RESERVED_HOLD: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // see R5
        burst_byte && !ADDR_LOAD && !STOP_DET && ptr_r == BRAP_ADDR_LAST
        |=> ptr_r == BRAP_ADDR_LAST)
        else $error("pointer left the reserved address");
    AST_BURST_FROM_ZERO: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // see R8
        burst_byte && !ADDR_LOAD && !STOP_DET && ptr_r == BRAP_ADDR_STATUS
        ##1 burst_byte && !ADDR_LOAD && !STOP_DET
        |=> ptr_r == BRAP_ADDR_X_MSB + BRAP_ADDR_STEP)
        else $error("burst from status did not reach data");

    AST_LOAD_TAKES: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // see R3
        ADDR_LOAD |=> ptr_r == $past(ADDR_IN))
        else $error("pointer did not take the new address");

    AST_INC_ANY: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // see R1
        burst_byte && !ADDR_LOAD && !(STOP_DET && !SPI_SEL) && ptr_r != BRAP_ADDR_LAST
        |=> ptr_r == $past(ptr_r) + BRAP_ADDR_STEP)
        else $error("pointer did not step on a burst byte");

    AST_IDLE_HOLD: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // see R1
        !ADDR_LOAD && !STOP_DET && !BYTE_DONE |=> $stable(ptr_r))
        else $error("pointer moved with no link event");

    AST_SPI_STOP_IGNORED: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // see R3
        STOP_DET && SPI_SEL && !ADDR_LOAD && !burst_byte |=> $stable(ptr_r))
        else $error("pointer rewound in spi mode");

    // -------------------------------------------------------------------------
    // Read events crossing into MCLK
    // -------------------------------------------------------------------------
    logic [AXES-1:0] rd_tgl_s;
    logic [AXES-1:0] rd_tgl_d_r;
    logic [AXES-1:0] rd_tgl_d_nxt;
    logic [AXES-1:0] clr_v;

    brap_sync #(
        .WIDTH(AXES)
    ) u_rd_sync (
        .clk(MCLK),
        .din(rd_tgl_r),
        .rst_val('0),
        .rst_en(!RST_B),
        .dout(rd_tgl_s)
    );

    assign clr_v = rd_tgl_s ^ rd_tgl_d_r;

    // -------------------------------------------------------------------------
    // Sample-ready flags and status alias, MCLK domain
    // -------------------------------------------------------------------------
    logic [7:0] dr_r;
    logic [7:0] dr_nxt;
    logic [AXES-1:0] seen_r;
    logic [AXES-1:0] seen_nxt;
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [AXES-1:0] new_v;
    logic sample_mode;

    assign new_v = {NEW_Z, NEW_Y, NEW_X};
    assign sample_mode = (F_MODE == BRAP_FMODE_SAMPLE);

    // The flags have no write path at all, so host writes cannot alter them.
    always_comb begin
        dr_nxt = dr_r; // see R10
        seen_nxt = seen_r | clr_v;
        rd_tgl_d_nxt = rd_tgl_s;
        status_nxt = sample_mode ? dr_r : FIFO_FLAGS; // see R6
        for (int i = 0; i < AXES; i++) begin
            if (clr_v[i]) begin
                dr_nxt[BRAP_DR_BIT + i] = 1'b0;
                dr_nxt[BRAP_OW_BIT + i] = 1'b0;
            end
            // New data wins over a clear landing in the same cycle.
            if (new_v[i]) begin
                dr_nxt[BRAP_DR_BIT + i] = 1'b1;
                if (dr_r[BRAP_DR_BIT + i] && sample_mode) begin
                    dr_nxt[BRAP_OW_BIT + i] = 1'b1;
                end
            end
        end
        if (&seen_nxt) begin
            dr_nxt[BRAP_ZYXDR_BIT] = 1'b0; // see R9
            dr_nxt[BRAP_ZYXOW_BIT] = 1'b0;
            seen_nxt = '0;
        end
        if (|new_v) begin
            dr_nxt[BRAP_ZYXDR_BIT] = 1'b1;
            if (dr_r[BRAP_ZYXDR_BIT] && sample_mode) begin
                dr_nxt[BRAP_ZYXOW_BIT] = 1'b1; // see R9
            end
        end
        if (!RST_B) begin
            dr_nxt = BRAP_STATUS_RESET; // see R7
            seen_nxt = '0;
            rd_tgl_d_nxt = '0;
            status_nxt = BRAP_STATUS_RESET;
        end
    end

    always_ff @(posedge MCLK) begin
        dr_r <= dr_nxt;
        seen_r <= seen_nxt;
        rd_tgl_d_r <= rd_tgl_d_nxt;
        status_r <= status_nxt;
    end

    assign STATUS_Q = status_r;

    // -------------------------------------------------------------------------
    // Status checks
    // -------------------------------------------------------------------------
    // Flags may only rise on new data, so no host access can ever set them.
    AST_FIFO_ALIAS: assert property (@(posedge MCLK) disable iff (!RST_B) // see R6
        F_MODE != BRAP_FMODE_SAMPLE |=> status_r == $past(FIFO_FLAGS))
        else $error("status does not show fifo flags");
    AST_SAMPLE_ALIAS: assert property (@(posedge MCLK) disable iff (!RST_B) // see R6
        sample_mode |=> status_r == $past(dr_r))
        else $error("status does not show sample flags");
    AST_RESET_ZERO: assert property (@(posedge MCLK) // see R7
        !RST_B |=> status_r == BRAP_STATUS_RESET && dr_r == BRAP_STATUS_RESET)
        else $error("status not zero after reset");
    AST_ZYXOW_SET: assert property (@(posedge MCLK) disable iff (!RST_B) // see R9
        sample_mode && (|new_v) && dr_r[BRAP_ZYXDR_BIT] |=> dr_r[BRAP_ZYXOW_BIT] ##1
        status_r[BRAP_ZYXOW_BIT] || !$past(sample_mode))
        else $error("overwrite flag not raised");
    AST_ZYXOW_HOLD: assert property (@(posedge MCLK) disable iff (!RST_B) // see R9
        dr_r[BRAP_ZYXOW_BIT] && !(&(seen_r | clr_v)) |=> dr_r[BRAP_ZYXOW_BIT])
        else $error("overwrite flag dropped before all reads");

    AST_NO_SET_WITHOUT_DATA: assert property (@(posedge MCLK) disable iff (!RST_B) // see R10
        !(|new_v) |=> (dr_r & ~$past(dr_r)) == 8'h00)
        else $error("flag rose without new data");

    AST_ZYXDR_SET: assert property (@(posedge MCLK) disable iff (!RST_B) // see R9
        (|new_v) |=> dr_r[BRAP_ZYXDR_BIT])
        else $error("all-axis ready flag not raised");

    AST_OW_ONLY_SAMPLE: assert property (@(posedge MCLK) disable iff (!RST_B) // see R9
        !sample_mode && !dr_r[BRAP_ZYXOW_BIT] |=> !dr_r[BRAP_ZYXOW_BIT])
        else $error("overwrite flag raised outside sample mode");

    AST_ZYX_CLEAR: assert property (@(posedge MCLK) disable iff (!RST_B) // see R9
        (&(seen_r | clr_v)) && !(|new_v) |=> !dr_r[BRAP_ZYXDR_BIT] && !dr_r[BRAP_ZYXOW_BIT])
        else $error("all-axis flags not cleared after all reads");

    // Per-axis ready flags follow each new sample.
    AST_XDR_SET: assert property (@(posedge MCLK) disable iff (!RST_B) // see R6
        new_v[0]
        |=> dr_r[BRAP_DR_BIT])
        else $error("x ready flag not raised");

    AST_YDR_SET: assert property (@(posedge MCLK) disable iff (!RST_B) // see R6
        new_v[1]
        |=> dr_r[BRAP_DR_BIT + 1])
        else $error("y ready flag not raised");

    AST_ZDR_SET: assert property (@(posedge MCLK) disable iff (!RST_B) // see R6
        new_v[2]
        |=> dr_r[BRAP_DR_BIT + 2])
        else $error("z ready flag not raised");

    // Per-axis overwrite flags rise in sample mode when unread data is replaced.
    AST_XOW_SET: assert property (@(posedge MCLK) disable iff (!RST_B) // see R9
        new_v[0] && dr_r[BRAP_DR_BIT] && sample_mode
        |=> dr_r[BRAP_OW_BIT])
        else $error("x overwrite flag not raised");

    AST_YOW_SET: assert property (@(posedge MCLK) disable iff (!RST_B) // see R9
        new_v[1] && dr_r[BRAP_DR_BIT + 1] && sample_mode
        |=> dr_r[BRAP_OW_BIT + 1])
        else $error("y overwrite flag not raised");

    AST_ZOW_SET: assert property (@(posedge MCLK) disable iff (!RST_B) // see R9
        new_v[2] && dr_r[BRAP_DR_BIT + 2] && sample_mode
        |=> dr_r[BRAP_OW_BIT + 2])
        else $error("z overwrite flag not raised");

    // A high-byte read clears that axis unless new data lands at once.
    AST_X_CLEAR: assert property (@(posedge MCLK) disable iff (!RST_B) // see R9
        clr_v[0] && !new_v[0]
        |=> !dr_r[BRAP_DR_BIT] && !dr_r[BRAP_OW_BIT])
        else $error("x flags not cleared by read");

    AST_Y_CLEAR: assert property (@(posedge MCLK) disable iff (!RST_B) // see R9
        clr_v[1] && !new_v[1]
        |=> !dr_r[BRAP_DR_BIT + 1] && !dr_r[BRAP_OW_BIT + 1])
        else $error("y flags not cleared by read");

    AST_Z_CLEAR: assert property (@(posedge MCLK) disable iff (!RST_B) // see R9
        clr_v[2] && !new_v[2]
        |=> !dr_r[BRAP_DR_BIT + 2] && !dr_r[BRAP_OW_BIT + 2])
        else $error("z flags not cleared by read");
endmodule : brap_top
`default_nettype wire

/* testbench/brap_host_model.sv */
// Host bus controller model that drives the link side of the pointer.
`default_nettype none
module brap_host_model (
    input wire logic link_clk,
    output logic addr_load,
    output logic [7:0] addr_in,
    output logic burst_rd,
    output logic byte_done,
    output logic stop_det,
    output logic spi_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr_load = 1'b0;
        addr_in = 8'h00;
        burst_rd = 1'b0;
        byte_done = 1'b0;
        stop_det = 1'b0;
        spi_sel = 1'b0;
    end
    task automatic load(input logic [7:0] a);
        @(negedge link_clk);
        addr_load = 1'b1;
        addr_in = a;
        @(negedge link_clk);
        addr_load = 1'b0;
        // A released address bus shows the inverse so stale data is never reused.
        addr_in = ~a;
    endtask : load
    task automatic read_bytes(input int n, input logic burst);
        repeat (n) begin
            @(negedge link_clk);
            burst_rd = burst;
            byte_done = 1'b1;
        end
        @(negedge link_clk);
        byte_done = 1'b0;
        burst_rd = 1'b0;
    endtask : read_bytes
    task automatic stop(input logic spi);
        @(negedge link_clk);
        spi_sel = spi;
        stop_det = 1'b1;
        @(negedge link_clk);
        stop_det = 1'b0;
    endtask : stop
endmodule : brap_host_model
`default_nettype wire

/* testbench/brap_top_tb_top.sv */
// Self-checking bench for the burst read address pointer and status alias.
`default_nettype none
module brap_top_tb_top;
    import brap_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] f_mode = 2'h0;
    logic [7:0] fifo_flags = 8'h00;
    logic new_x = 1'b0;
    logic new_y = 1'b0;
    logic new_z = 1'b0;
    logic addr_load, burst_rd, byte_done, stop_det, spi_sel;
    logic [7:0] addr_in, ptr, status_q;
    int miscompares = 0;
    int total_checks = 0;
    brap_top uut (.MCLK(mclk), .RST_B(rst_b), .LINK_CLK(link_clk), .ADDR_LOAD(addr_load),
        .ADDR_IN(addr_in), .BURST_RD(burst_rd), .BYTE_DONE(byte_done), .STOP_DET(stop_det),
        .SPI_SEL(spi_sel), .F_MODE(f_mode), .FIFO_FLAGS(fifo_flags), .NEW_X(new_x),
        .NEW_Y(new_y), .NEW_Z(new_z), .PTR(ptr), .STATUS_Q(status_q));
    brap_host_model host (.link_clk(link_clk), .addr_load(addr_load), .addr_in(addr_in),
        .burst_rd(burst_rd), .byte_done(byte_done), .stop_det(stop_det), .spi_sel(spi_sel));
    initial begin
        forever #2 mclk = ~mclk;
    end
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic ptr_is(input logic [7:0] exp);
        @(negedge link_clk);
        check(ptr, exp);
    endtask : ptr_is
    // Status changes cross clocks, so wait for them under a bound.
    task automatic status_is(input logic [7:0] m, input logic [7:0] exp);
        for (int i = 0; i < 40 && (status_q & m) !== exp; i++) begin
            @(negedge mclk);
        end
        check(status_q & m, exp);
        if ((status_q & m) !== exp) summarize();
    endtask : status_is
    task automatic axis(input logic [2:0] a);
        @(negedge mclk);
        {new_z, new_y, new_x} = a;
        @(negedge mclk);
        {new_z, new_y, new_x} = 3'h0;
    endtask : axis
    initial begin
        #100us;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (16) @(negedge mclk);
        check(status_q, BRAP_STATUS_RESET);
        rst_b = 1'b1;
        repeat (4) @(negedge link_clk);
        check(ptr, BRAP_PTR_RESET);
        host.load(8'h00);
        host.read_bytes(3, 1'b1);
        ptr_is(8'h03);
        host.read_bytes(2, 1'b0);
        ptr_is(8'h03);
        host.stop(1'b1);
        ptr_is(8'h03);
        host.stop(1'b0);
        ptr_is(8'h00);
        $display("pointer test done");
        host.load(8'h68);
        host.read_bytes(17, 1'b1);
        ptr_is(8'h79);
        host.read_bytes(2, 1'b1);
        ptr_is(8'h79);
        $display("range test done");
        axis(3'h1);
        status_is(8'hff, 8'h09);
        axis(3'h1);
        status_is(8'h99, 8'h99);
        for (int a = 1; a <= 5; a += 2) begin
            host.load(a[7:0]);
            host.read_bytes(1, 1'b0);
        end
        status_is(8'h88, 8'h00);
        $display("status test done");
        for (int m = 1; m < 4; m++) begin
            @(negedge mclk);
            f_mode = m[1:0];
            fifo_flags = {m[1:0], 6'h25};
            status_is(8'hff, {m[1:0], 6'h25});
        end
        $display("fifo test done");
        summarize();
    end
endmodule : brap_top_tb_top
`default_nettype wire
